/* src/bpp_port.sv */
/*
 * Byte-wide general-purpose pin port with per-pin direction, output
 * latch, readback select, input pull-ups and sharing with the low data
 * bus lines. Registers sit behind a classic Wishbone slave.
 * Assumes the bus controller drives the low data lines and their enable
 * on this clock, and that standby inputs are levels on this clock.
 */
module bpp_port
    import bpp_pkg::*;
#(
    parameter logic [7:0] BUS_WIDTH_RESET = RST_BUS_WIDTH
)
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              hw_standby_i,
    input  wire logic              sw_standby_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [SEL_W-1:0]  wb_sel_i,
    input  wire logic [DAT_W-1:0]  wb_dat_i,
    output      logic [DAT_W-1:0]  wb_dat_o,
    output      logic              wb_ack_o,
    input  wire logic [PORT_W-1:0] pin_i,
    output      logic [PORT_W-1:0] pin_o,
    output      logic [PORT_W-1:0] pin_oe_o,
    output      logic [PORT_W-1:0] pullup_en_o,
    input  wire logic [PORT_W-1:0] dbus_out_i,
    input  wire logic              dbus_oe_i,
    output      logic [PORT_W-1:0] dbus_in_o,
    output      logic              bus16_mode_o
);

    // ----------------------------------------------------------------
    // decode helper
    // ----------------------------------------------------------------
    function automatic logic idx_hit(input logic [ADR_W-1:0] adr, input logic [19:0] idx);
        return adr[ADR_W-1:2] == idx;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bpp_bus_state_t    bus_q;
    bpp_bus_state_t    bus_d;
    logic [PORT_W-1:0] dir_q;
    logic [PORT_W-1:0] out_q;
    logic [PORT_W-1:0] pcr_q;
    logic [PORT_W-1:0] bwc_q;
    logic [PORT_W-1:0] pin_oe_q;
    logic [PORT_W-1:0] pin_o_q;
    logic [PORT_W-1:0] pullup_q;
    logic [PORT_W-1:0] dbus_in_q;
    logic [DAT_W-1:0]  rdat_q;
    logic [PORT_W-1:0] pin_lvl;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire               clr        = rst_i | hw_standby_i;
    wire               req        = wb_cyc_i & wb_stb_i;
    wire               wr_go      = req & wb_we_i & wb_sel_i[0] & (bus_q == BPP_BUS_ACK);
    wire               hit_dir    = idx_hit(wb_adr_i, IDX_PIN_DIR);
    wire               hit_pcr    = idx_hit(wb_adr_i, IDX_PULLUP);
    wire               hit_out    = idx_hit(wb_adr_i, IDX_OUT_DATA);
    wire               hit_bwc    = idx_hit(wb_adr_i, IDX_BUS_WIDTH);
    wire               hit_sts    = idx_hit(wb_adr_i, IDX_STATUS);
    wire [PORT_W-1:0]  wdat       = wb_dat_i[PORT_W-1:0];

    // sixteen-bit mode if any area is 16-bit
    wire               bus16      = (bwc_q != ALL_8BIT);

    wire [PORT_W-1:0]  out_rd     = (dir_q & out_q) | (~dir_q & pin_lvl);
    wire [PORT_W-1:0]  sts_rd     = (PORT_W'(bus16) << ST_BUS16)
                                    | (PORT_W'(sw_standby_i) << ST_SW_STBY)
                                    | (PORT_W'(hw_standby_i) << ST_HW_STBY);

    // direction reads back as ones, its value is not visible
    wire [PORT_W-1:0]  rd_byte    = hit_dir ? RD_WRITE_ONLY :
                                    hit_out ? out_rd :
                                    hit_pcr ? pcr_q :
                                    hit_bwc ? bwc_q :
                                    hit_sts ? sts_rd : ALL_OFF;

    // ----------------------------------------------------------------
    // pin drive and pull-up selection
    // ----------------------------------------------------------------
    // drivers from direction or data bus enable
    wire [PORT_W-1:0]  pin_oe_d   = hw_standby_i ? ALL_OFF :
                                    bus16 ? {PORT_W{dbus_oe_i}} : dir_q;
    // output pins carry the data latch in eight-bit mode, the data bus outputs in sixteen-bit mode
    wire [PORT_W-1:0]  pin_o_d    = bus16 ? dbus_out_i : out_q;
    // pull-up only for inputs in eight-bit mode
    wire [PORT_W-1:0]  pullup_d   = (hw_standby_i | bus16) ? ALL_OFF : (pcr_q & ~dir_q);

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // one wait state, ack for one cycle, then back to idle
    always_comb
    begin
        bus_d = bus_q;
        case (bus_q)
            BPP_BUS_IDLE:
            begin
                if (req)
                begin
                    bus_d = BPP_BUS_ACK;
                end
            end
            BPP_BUS_ACK:
            begin
                bus_d = BPP_BUS_IDLE;
            end
            default:
            begin
                bus_d = BPP_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_q <= BPP_BUS_IDLE;
        end
        else
        begin
            bus_q <= bus_d;
        end
    end

    // read data captured in the request cycle, shown with ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_q <= '0;
        end
        else if (req && bus_q == BPP_BUS_IDLE)
        begin
            rdat_q <= {24'h000000, rd_byte};
        end
    end

    assign wb_ack_o = (bus_q == BPP_BUS_ACK);
    assign wb_dat_o = rdat_q;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // cleared by reset or hardware standby, written at ack
    // software standby has no term here, so values simply hold
    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            dir_q <= RST_PIN_DIR;
            out_q <= RST_OUT_DATA;
            pcr_q <= RST_PULLUP;
        end
        else
        begin
            if (wr_go && hit_dir)
            begin
                dir_q <= wdat;
            end
            if (wr_go && hit_out)
            begin
                out_q <= wdat;
            end
            if (wr_go && hit_pcr)
            begin
                pcr_q <= wdat;
            end
        end
    end

    // bus width lives in the bus controller, so only reset clears it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bwc_q <= BUS_WIDTH_RESET;
        end
        else if (wr_go && hit_bwc)
        begin
            bwc_q <= wdat;
        end
    end

    // registered pin drive, one edge after the register changes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_oe_q  <= ALL_OFF;
            pin_o_q   <= ALL_OFF;
            pullup_q  <= ALL_OFF;
            dbus_in_q <= ALL_OFF;
        end
        else
        begin
            pin_oe_q  <= pin_oe_d;
            pin_o_q   <= pin_o_d;
            pullup_q  <= pullup_d;
            dbus_in_q <= pin_lvl;
        end
    end

    assign pin_oe_o     = pin_oe_q;
    assign pin_o        = pin_o_q;
    assign pullup_en_o  = pullup_q;
    assign dbus_in_o    = dbus_in_q;
    assign bus16_mode_o = bus16;

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    // pins are asynchronous, so levels pass the synchroniser
    bpp_pin_sync #(
        .WIDTH   (PORT_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pin_i),
        .level_o (pin_lvl)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_mode_select: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_go && hit_bwc) |=> (bus16_mode_o == ($past(wdat) != ALL_8BIT)))
        else $error("bus mode disagrees with bus width areas");

    a_dir_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (!bus16 && !hw_standby_i) |=> (pin_oe_o == $past(dir_q)))
        else $error("pin enables do not follow direction in 8-bit mode");

    a_bus16_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus16 && !hw_standby_i) |=> (pin_oe_o == {PORT_W{$past(dbus_oe_i)}})
                                      && (pin_o == $past(dbus_out_i)))
        else $error("pins do not carry data bus in 16-bit mode");

    a_dir_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && !wb_we_i && hit_dir) |-> (wb_dat_o[7:0] == RD_WRITE_ONLY))
        else $error("direction register value leaked on read");

    a_dir_clear: assert property (@(posedge clk_i)
        clr |=> (dir_q == RST_PIN_DIR) && (out_q == RST_OUT_DATA) && (pcr_q == RST_PULLUP))
        else $error("direction, data or pull-up control not cleared");

    a_standby_hold: assert property (@(posedge clk_i) disable iff (clr)
        (sw_standby_i && !wr_go) |=> $stable(dir_q) && $stable(pcr_q) && $stable(out_q) && $stable(bwc_q))
        else $error("register changed in software standby");

    a_standby_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (sw_standby_i && !hw_standby_i && !bus16) ##1 (sw_standby_i && $stable(dir_q))
        |-> ((pin_oe_o & dir_q) == dir_q))
        else $error("output dropped in software standby");

    a_out_level: assert property (@(posedge clk_i) disable iff (rst_i)
        !bus16 |=> (pin_o == $past(out_q)))
        else $error("pin level differs from output latch");

    a_read_mux: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_out && bus_q == BPP_BUS_IDLE)
        |=> (wb_dat_o[7:0] == (($past(dir_q) & $past(out_q)) | (~$past(dir_q) & $past(pin_lvl)))))
        else $error("data readback select wrong");

    a_pullup_on: assert property (@(posedge clk_i) disable iff (rst_i)
        (!bus16 && !hw_standby_i) |=> (pullup_en_o == ($past(pcr_q) & ~$past(dir_q))))
        else $error("pull-up enable wrong in 8-bit mode");

    a_pullup_off: assert property (@(posedge clk_i)
        (rst_i || hw_standby_i || bus16) |=> (pullup_en_o == ALL_OFF))
        else $error("pull-up on in reset, standby or 16-bit mode");

    a_write_take: assert property (@(posedge clk_i) disable iff (clr)
        (wr_go && hit_pcr) |=> (pcr_q == $past(wdat))
        ##1 ($past(bus16) || (pullup_en_o == ($past(pcr_q) & ~$past(dir_q)))))
        else $error("pull-up write not taken");

    a_dir_write: assert property (@(posedge clk_i) disable iff (clr)
        (wr_go && hit_dir) |=> (dir_q == $past(wdat)))
        else $error("direction write not taken");

    a_out_write: assert property (@(posedge clk_i) disable iff (clr)
        (wr_go && hit_out) |=> (out_q == $past(wdat)))
        else $error("output data write not taken");

    a_sel_ignore: assert property (@(posedge clk_i) disable iff (clr)
        (req && wb_we_i && !wb_sel_i[0] && bus_q == BPP_BUS_ACK)
        |=> $stable(out_q) && $stable(dir_q) && $stable(pcr_q) && $stable(bwc_q))
        else $error("write without low byte select changed a register");

    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && bus_q == BPP_BUS_IDLE) |=> wb_ack_o)
        else $error("request not acknowledged after one wait state");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");

    a_hw_drive_off: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_standby_i |=> (pin_oe_o == ALL_OFF) && (pullup_en_o == ALL_OFF))
        else $error("pins driven or pulled up in hardware standby");

    a_dbus_in: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (dbus_in_o == $past(pin_lvl)))
        else $error("data bus input does not follow pin level");

    a_pcr_read: assert property (@(posedge clk_i) disable iff (clr)
        (req && !wb_we_i && hit_pcr && bus_q == BPP_BUS_IDLE) |=> (wb_dat_o[7:0] == $past(pcr_q)))
        else $error("pull-up control readback wrong");

    a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && bus_q == BPP_BUS_IDLE && !(hit_dir || hit_pcr || hit_out || hit_bwc || hit_sts))
        |=> (wb_dat_o == '0))
        else $error("unmapped read returned nonzero data");

    a_bwc_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        (hw_standby_i && !(wr_go && hit_bwc)) |=> $stable(bwc_q))
        else $error("bus width changed by hardware standby");

    a_dat_upper: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> (wb_dat_o[DAT_W-1:PORT_W] == '0))
        else $error("read data upper bytes not zero");

endmodule

/* src/bpp_pkg.sv */
/*
 * Constants for the byte-wide pin port: register indices, reset values,
 * field layout of the status word and bus geometry.
 * Assumes a 32-bit classic Wishbone slave where each register sits in
 * the low byte of one word, at byte address four times its index.
 */
package bpp_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int          ADR_W         = 22;
    localparam int          IDX_W         = 20;
    localparam int          DAT_W         = 32;
    localparam int          SEL_W         = 4;
    localparam int          PORT_W        = 8;

    // ----------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [19:0] IDX_PIN_DIR   = 20'hEE003;
    localparam logic [19:0] IDX_PULLUP    = 20'hEE03E;
    localparam logic [19:0] IDX_OUT_DATA  = 20'hFFFD3;
    localparam logic [19:0] IDX_BUS_WIDTH = 20'hEE040;
    localparam logic [19:0] IDX_STATUS    = 20'hEE041;

    // ----------------------------------------------------------------
    // reset values and read-back constants
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_PIN_DIR   = 8'h00;
    localparam logic [7:0]  RST_PULLUP    = 8'h00;
    localparam logic [7:0]  RST_OUT_DATA  = 8'h00;
    localparam logic [7:0]  RST_BUS_WIDTH = 8'h00;
    localparam logic [7:0]  RD_WRITE_ONLY = 8'hFF;
    localparam logic [7:0]  ALL_OFF       = 8'h00;
    localparam logic [7:0]  ALL_8BIT      = 8'h00;

    // ----------------------------------------------------------------
    // status word fields
    // ----------------------------------------------------------------
    localparam int          ST_BUS16      = 0;
    localparam int          ST_SW_STBY    = 1;
    localparam int          ST_HW_STBY    = 2;

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    localparam int          SYNC_STAGES   = 3;

    typedef enum logic
    {
        BPP_BUS_IDLE,
        BPP_BUS_ACK
    } bpp_bus_state_t;

endpackage

/* src/bpp_pin_sync.sv */
/*
 * Three-stage synchroniser for the port pins with agreement filter.
 * Assumes asynchronous pin levels; the filtered level follows a pin
 * only once the second and third stages agree.
 */
module bpp_pin_sync
    import bpp_pkg::*;
#(
    parameter int WIDTH = PORT_W
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output      logic [WIDTH-1:0] level_o
);

    // ----------------------------------------------------------------
    // per-bit stages
    // ----------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < WIDTH; k++)
        begin : g_bit
            logic [SYNC_STAGES-1:0] stage_q;
            logic                   level_q;

            // stage 0 is read only by stage 1
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    stage_q <= '0;
                end
                else
                begin
                    stage_q <= {stage_q[SYNC_STAGES-2:0], pin_i[k]};
                end
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    level_q <= 1'b0;
                end
                else if (stage_q[1] == stage_q[2])
                begin
                    level_q <= stage_q[2];
                end
            end

            assign level_o[k] = level_q;
        end
    endgenerate

endmodule

/* sim/bpp_pin_model.sv */
/*
 * Board-side model of the eight port pins: resolves each wire from the
 * port's drive, an external driver and the on-chip pull-up.
 * Assumes the bench steers the external driver on the port clock.
 */
module bpp_pin_model
    import bpp_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [PORT_W-1:0] pin_oe_i,
    input  wire logic [PORT_W-1:0] pin_val_i,
    input  wire logic [PORT_W-1:0] pullup_en_i,
    input  wire logic [PORT_W-1:0] ext_en_i,
    input  wire logic [PORT_W-1:0] ext_val_i,
    output      logic [PORT_W-1:0] level_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // a floating pin wanders, so nothing may rely on its last value
    logic [PORT_W-1:0] float_q = 8'h55;

    always @(posedge clk_i)
    begin
        float_q <= ~float_q;
    end

    // port drive wins, then the board, then the pull-up
    assign level_o = (pin_oe_i & pin_val_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                   | (~pin_oe_i & ~ext_en_i & pullup_en_i)
                   | (~pin_oe_i & ~ext_en_i & ~pullup_en_i & float_q);
endmodule

/* sim/bpp_port_tb.sv */
/*
 * Self-checking bench for the byte-wide pin port: registers over
 * classic Wishbone, pin drive, readback, pull-ups and bus sharing.
 * Assumes the board model in bpp_pin_model and the package constants.
 */
module bpp_port_tb
    import bpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk_i = 0, rst_i = 1, hw_sb = 0, sw_sb = 0;
    logic              cyc = 0, stb = 0, we = 0, ack, bus16, dbus_oe = 0;
    logic [ADR_W-1:0]  adr = '0;
    logic [SEL_W-1:0]  sel = '0;
    logic [DAT_W-1:0]  wdat = '0, rdat;
    logic [PORT_W-1:0] lvl, pout, poe, pu, dbus_out = '0, dbus_in, ext_en = '0, ext_val = '0, q;
    int                num_errors = 0, num_checks = 0, cycles = 0;

    always #5 clk_i = ~clk_i;

    bpp_port DUT (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hw_sb), .sw_standby_i(sw_sb),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(lvl), .pin_o(pout),
        .pin_oe_o(poe), .pullup_en_o(pu), .dbus_out_i(dbus_out), .dbus_oe_i(dbus_oe),
        .dbus_in_o(dbus_in), .bus16_mode_o(bus16));

    bpp_pin_model board (.clk_i(clk_i), .pin_oe_i(poe), .pin_val_i(pout), .pullup_en_i(pu),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle; ack and read data are taken at the same edge
    task automatic wb(input logic w, input logic [19:0] idx, input logic [7:0] d,
                      input logic [3:0] s, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        sel  <= s;
        wdat <= {24'h000000, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n == 50)
            chk("ack", 8'h00, 8'h01);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [19:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'h1, q);
    endtask

    task automatic rd_chk(input string name, input logic [19:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00, 4'hF, q);
        chk(name, q, exp);
    endtask

    task automatic settle(input int n);
        // outputs are read as they stood just before this edge
        repeat (n) @(posedge clk_i);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("pin_oe", poe, 8'h00);
        chk("pullup_en", pu, ALL_OFF);
        chk("bus16", {7'h00, bus16}, 8'h00);
        rd_chk("pullup_control", IDX_PULLUP, RST_PULLUP);
        rd_chk("pin_direction", IDX_PIN_DIR, RD_WRITE_ONLY);
        wr(IDX_PIN_DIR, 8'hFF);
        rd_chk("output_data", IDX_OUT_DATA, RST_OUT_DATA);
        $display("test reset done");
    endtask

    task automatic t_io();
        wr(IDX_OUT_DATA, 8'hA5);
        wr(IDX_PIN_DIR, 8'h0F);
        settle(1);
        chk("pin_oe", poe, 8'hFF);
        settle(1);
        chk("pin_oe", poe, 8'h0F);
        ext_en  <= 8'hF0;
        ext_val <= 8'h3C;
        settle(6);
        chk("pin_oe", poe, 8'h0F);
        chk("pin_o", pout & 8'h0F, 8'h05);
        rd_chk("output_data", IDX_OUT_DATA, 8'h35);
        rd_chk("pin_direction", IDX_PIN_DIR, RD_WRITE_ONLY);
        $display("test io done");
    endtask

    task automatic t_pullup();
        ext_en <= 8'h00;
        wr(IDX_PULLUP, 8'hFF);
        settle(6);
        chk("pullup_en", pu, 8'hF0);
        rd_chk("output_data", IDX_OUT_DATA, 8'hF5);
        rd_chk("pullup_control", IDX_PULLUP, 8'hFF);
        sw_sb <= 1'b1;
        settle(2);
        chk("pin_oe", poe, 8'h0F);
        chk("pullup_en", pu, 8'hF0);
        rd_chk("output_data", IDX_OUT_DATA, 8'hF5);
        rd_chk("pullup_control", IDX_PULLUP, 8'hFF);
        rd_chk("status", IDX_STATUS, 8'h01 << ST_SW_STBY);
        sw_sb <= 1'b0;
        $display("test pullup done");
    endtask

    task automatic t_bus16();
        dbus_out <= 8'hC3;
        dbus_oe  <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            wr(IDX_BUS_WIDTH, 8'h01 << i);
            settle(1);
            chk("bus16", {7'h00, bus16}, 8'h01);
        end
        settle(1);
        chk("pullup_en", pu, ALL_OFF);
        chk("pin_oe", poe, 8'hFF);
        chk("pin_o", pout, 8'hC3);
        rd_chk("bus_width_config", IDX_BUS_WIDTH, 8'h80);
        rd_chk("status", IDX_STATUS, 8'h01 << ST_BUS16);
        dbus_oe <= 1'b0;
        ext_en  <= 8'hFF;
        ext_val <= 8'h5A;
        settle(8);
        chk("pin_oe", poe, 8'h00);
        chk("dbus_in", dbus_in, 8'h5A);
        ext_en <= 8'hF0;
        wr(IDX_BUS_WIDTH, ALL_8BIT);
        settle(2);
        chk("bus16", {7'h00, bus16}, 8'h00);
        chk("pullup_en", pu, 8'hF0);
        $display("test bus16 done");
    endtask

    task automatic t_hw_standby();
        ext_en <= 8'h00;
        hw_sb  <= 1'b1;
        settle(2);
        hw_sb <= 1'b0;
        chk("pin_oe", poe, 8'h00);
        chk("pullup_en", pu, ALL_OFF);
        rd_chk("pullup_control", IDX_PULLUP, RST_PULLUP);
        wr(IDX_PIN_DIR, 8'hFF);
        rd_chk("output_data", IDX_OUT_DATA, RST_OUT_DATA);
        $display("test hw_standby done");
    endtask

    task automatic t_refused();
        wr(IDX_OUT_DATA, 8'h3C);
        wb(1'b1, IDX_OUT_DATA, 8'hC3, 4'hE, q);
        rd_chk("output_data", IDX_OUT_DATA, 8'h3C);
        wr(20'h00010, 8'h55);
        rd_chk("unmapped", 20'h00010, 8'h00);
        settle(1);
        chk("pin_o", pout, 8'h3C);
        $display("test refused done");
    endtask

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(1);
        t_reset();
        t_io();
        t_pullup();
        t_bus16();
        t_hw_standby();
        t_refused();
        print_verdict();
    end
endmodule
